// ===== core/dpsem_defines.vh
// Purpose: constants for the dual-port semaphore port controller
// Assumes: one 125 MHz clock, asynchronous active-low reset
// Notes: timing counts are whole clock cycles of 8 ns
//
// Contract
// R1: first low request latch wins token
// R2: owner keeps token until writing one
// R3: release hands token to pending side
// R4: new owner holds until it writes one
// R5: concurrent claims grant exactly one port
// R6: earlier request wins a free token
// R7: simultaneous requests pick one arbitrarily
// R8: failed claim: keep reading or withdraw
// R9: release unused token by writing one
// R10: claim by write then read back
// R11: device latches start undefined
// R12: write one to all flags at start
// R13: eight independent semaphores
// R14: read zero means claim succeeded
// R15: flags active low, zero claims
// R16: only data bit zero is written
// R17: read value fills all data bits
// R18: read latched while select and enable low
// R19: reads never change semaphore state
`ifndef DPSEM_DEFINES_VH
`define DPSEM_DEFINES_VH

// ==========================================
// command codes
`define DPSEM_CMD_CLAIM 2'h0
`define DPSEM_CMD_RELEASE 2'h1
`define DPSEM_CMD_PROBE 2'h2
`define DPSEM_CMD_WITHDRAW 2'h3

// ==========================================
// pin timing, in ns, and cycles at 125 MHz
`define DPSEM_CLK_NS 8
`define DPSEM_STROBE_NS 35
`define DPSEM_STROBE_CYC ((`DPSEM_STROBE_NS + `DPSEM_CLK_NS - 1) / `DPSEM_CLK_NS)
`define DPSEM_GAP_NS 15
`define DPSEM_GAP_CYC ((`DPSEM_GAP_NS + `DPSEM_CLK_NS - 1) / `DPSEM_CLK_NS)

// ==========================================
// data values
`define DPSEM_FLAG_BIT 0
`define DPSEM_SEM_COUNT 8
`define DPSEM_ADDR_W 3
`define DPSEM_FREE 1'h1
`define DPSEM_TAKEN 1'h0

`endif

// ===== core/dpsem_cycle.v
// Purpose: one strobe of the flag space: write or read cycle on the pins
// Assumes: pins synchronous to clock_i
// Notes: select and enable rise between cycles so the device latch reloads
`timescale 1ns/1ps
`include "dpsem_defines.vh"

module dpsem_cycle #(
	parameter STROBE_CYC = `DPSEM_STROBE_CYC,
	parameter GAP_CYC = `DPSEM_GAP_CYC
) (
	input wire clock_i,
	input wire arst_n_i,
	input wire start_i,
	input wire write_i,
	input wire wbit_i,
	input wire [15:0] data_in_i,
	output reg flag_space_select_n_o,
	output reg write_n_o,
	output reg read_enable_n_o,
	output reg data_oe_o,
	output reg [15:0] data_out_o,
	output reg done_o,
	output reg rbit_o,
	output reg busy_o
);
	localparam ST_IDLE = 2'h0;
	localparam ST_STROBE = 2'h1;
	localparam ST_GAP = 2'h2;

	reg [1:0] state;
	reg [7:0] count;
	reg is_write;

	// ==========================================
	// strobe sequencer
	always @(posedge clock_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			state <= ST_IDLE;
			count <= 8'h00;
			is_write <= 1'b0;
			flag_space_select_n_o <= 1'b1;
			write_n_o <= 1'b1;
			read_enable_n_o <= 1'b1;
			data_oe_o <= 1'b0;
			data_out_o <= 16'h0000;
			done_o <= 1'b0;
			rbit_o <= 1'b1;
			busy_o <= 1'b0;
		end else begin
			done_o <= 1'b0;
			case (state)
			ST_IDLE: begin
				if (start_i) begin
					state <= ST_STROBE;
					busy_o <= 1'b1;
					is_write <= write_i;
					count <= STROBE_CYC[7:0];
					flag_space_select_n_o <= 1'b0;
					write_n_o <= ~write_i;
					read_enable_n_o <= write_i;
					data_oe_o <= write_i;
					// bit zero carries the flag, others zero
					data_out_o <= {15'h0000, wbit_i}; // R16
				end
			end
			ST_STROBE: begin
				if (count <= 8'h01) begin
					if (!is_write) begin
						// one bit stands for the replicated flag
						rbit_o <= data_in_i[`DPSEM_FLAG_BIT]; // R17
					end
					// deselect so next read captures fresh value
					flag_space_select_n_o <= 1'b1; // R18
					write_n_o <= 1'b1;
					read_enable_n_o <= 1'b1;
					count <= GAP_CYC[7:0];
					state <= ST_GAP;
				end else begin
					count <= count - 8'h01;
				end
			end
			ST_GAP: begin
				// data stays driven one cycle past the strobe for hold time
				data_oe_o <= 1'b0; // R16
				if (count <= 8'h01) begin
					state <= ST_IDLE;
					busy_o <= 1'b0;
					done_o <= 1'b1;
				end else begin
					count <= count - 8'h01;
				end
			end
			default: begin
				state <= ST_IDLE;
			end
			endcase
		end
	end
endmodule

// ===== core/dpsem_host.v
// Purpose: port controller driving the semaphore flags of a dual-port memory
// Assumes: one port of the device; pins synchronous to clock_i
// Notes: claims are write then read; init frees all eight flags first
`timescale 1ns/1ps
`include "dpsem_defines.vh"

module dpsem_host #(
	parameter SEM_COUNT = `DPSEM_SEM_COUNT,
	parameter STROBE_CYC = `DPSEM_STROBE_CYC,
	parameter GAP_CYC = `DPSEM_GAP_CYC
) (
	input wire clock_i,
	input wire arst_n_i,
	input wire cmd_valid_i,
	input wire [1:0] cmd_op_i,
	input wire [2:0] cmd_index_i,
	output reg cmd_ready_o,
	output reg resp_valid_o,
	output reg resp_granted_o,
	output reg [7:0] owned_o,
	output reg [7:0] pending_o,
	output reg [2:0] sem_addr_o,
	output wire flag_space_select_n_o,
	output wire write_n_o,
	output wire read_enable_n_o,
	output wire data_oe_o,
	output wire [15:0] data_out_o,
	input wire [15:0] data_in_i
);
	localparam ST_INIT = 3'h0;
	localparam ST_INIT_WAIT = 3'h1;
	localparam ST_IDLE = 3'h2;
	localparam ST_WR_WAIT = 3'h3;
	localparam ST_RD = 3'h4;
	localparam ST_RD_WAIT = 3'h5;

	reg [2:0] state;
	reg [1:0] op;
	reg start;
	reg write;
	reg wbit;
	wire done;
	wire rbit;
	wire cyc_busy;

	// ==========================================
	// pin sequencer; pin outputs are its flip-flops
	dpsem_cycle #(
		.STROBE_CYC(STROBE_CYC),
		.GAP_CYC(GAP_CYC)
	) u_cycle (
		.clock_i(clock_i),
		.arst_n_i(arst_n_i),
		.start_i(start),
		.write_i(write),
		.wbit_i(wbit),
		.data_in_i(data_in_i),
		.flag_space_select_n_o(flag_space_select_n_o),
		.write_n_o(write_n_o),
		.read_enable_n_o(read_enable_n_o),
		.data_oe_o(data_oe_o),
		.data_out_o(data_out_o),
		.done_o(done),
		.rbit_o(rbit),
		.busy_o(cyc_busy)
	);

	// ==========================================
	// command flow: init, claim, release, probe, withdraw
	always @(posedge clock_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			state <= ST_INIT;
			op <= `DPSEM_CMD_PROBE;
			start <= 1'b0;
			write <= 1'b0;
			wbit <= `DPSEM_FREE;
			cmd_ready_o <= 1'b0;
			resp_valid_o <= 1'b0;
			resp_granted_o <= 1'b0;
			owned_o <= 8'h00;
			pending_o <= 8'h00;
			sem_addr_o <= 3'h0;
		end else begin
			start <= 1'b0;
			resp_valid_o <= 1'b0;
			case (state)
			ST_INIT: begin
				// device latches start undefined, so free each one
				if (!cyc_busy && !start) begin // R11
					start <= 1'b1;
					write <= 1'b1;
					wbit <= `DPSEM_FREE; // R12
					state <= ST_INIT_WAIT;
				end
			end
			ST_INIT_WAIT: begin
				if (done) begin
					if (sem_addr_o == SEM_COUNT[2:0] - 3'h1) begin // R13
						sem_addr_o <= 3'h0;
						cmd_ready_o <= 1'b1;
						state <= ST_IDLE;
					end else begin
						sem_addr_o <= sem_addr_o + 3'h1;
						state <= ST_INIT;
					end
				end
			end
			ST_IDLE: begin
				if (cmd_valid_i) begin
					cmd_ready_o <= 1'b0;
					op <= cmd_op_i;
					sem_addr_o <= cmd_index_i;
					start <= 1'b1;
					if (cmd_op_i == `DPSEM_CMD_PROBE) begin
						// a probe only reads; no latch changes
						write <= 1'b0; // R19
						state <= ST_RD_WAIT;
					end else begin
						write <= 1'b1;
						// zero requests, one releases or withdraws
						wbit <= (cmd_op_i == `DPSEM_CMD_CLAIM) ? `DPSEM_TAKEN : `DPSEM_FREE; // R15
						state <= ST_WR_WAIT;
					end
				end
			end
			ST_WR_WAIT: begin
				if (done) begin
					if (op == `DPSEM_CMD_CLAIM) begin
						// verify claim by reading back after the write
						state <= ST_RD; // R10
					end else begin
						// release or withdraw clears own request
						owned_o[sem_addr_o] <= 1'b0; // R9
						pending_o[sem_addr_o] <= 1'b0; // R8
						resp_granted_o <= 1'b0;
						resp_valid_o <= 1'b1;
						cmd_ready_o <= 1'b1;
						state <= ST_IDLE;
					end
				end
			end
			ST_RD: begin
				start <= 1'b1;
				write <= 1'b0;
				state <= ST_RD_WAIT;
			end
			ST_RD_WAIT: begin
				if (done) begin
					// zero read back means this side holds the token
					resp_granted_o <= (rbit == `DPSEM_TAKEN); // R14
					resp_valid_o <= 1'b1;
					cmd_ready_o <= 1'b1;
					state <= ST_IDLE;
					if (op == `DPSEM_CMD_CLAIM || pending_o[sem_addr_o]) begin
						// failed claim stays pending until retried or withdrawn
						owned_o[sem_addr_o] <= (rbit == `DPSEM_TAKEN); // R8
						pending_o[sem_addr_o] <= (rbit != `DPSEM_TAKEN);
					end
				end
			end
			default: begin
				state <= ST_IDLE;
			end
			endcase
		end
	end
endmodule

// ===== verification/dpsem_monitor.sv
// Purpose: pin timing checks on the host port controller
// Assumes: default strobe of 5 cycles and gap of 2
// Notes: bound to dpsem_host
`timescale 1ns/1ps
module dpsem_mon (
	input wire clock_i,
	input wire arst_n_i,
	input wire cmd_ready_o,
	input wire resp_valid_o,
	input wire [2:0] sem_addr_o,
	input wire flag_space_select_n_o,
	input wire write_n_o,
	input wire read_enable_n_o,
	input wire data_oe_o,
	input wire [15:0] data_out_o
);
	// ==========================================
	// properties
	default clocking @(posedge clock_i); endclocking
	default disable iff (!arst_n_i);
	a_write_drives: assert property (!write_n_o |-> data_oe_o && !flag_space_select_n_o)
		else $error("write strobe without select or drive");
	a_upper_zero: assert property (data_oe_o |-> data_out_o[15:1] == 15'h0)
		else $error("upper data bits driven");
	a_no_overlap: assert property (!(!write_n_o && !read_enable_n_o))
		else $error("write and read together");
	a_write_len: assert property ($fell(write_n_o) |-> !write_n_o [*5] ##1 write_n_o)
		else $error("write strobe length");
	a_read_len: assert property ($fell(read_enable_n_o) |-> !read_enable_n_o [*5] ##1 read_enable_n_o)
		else $error("read strobe length");
	a_gap_high: assert property ($rose(flag_space_select_n_o) |-> flag_space_select_n_o [*2])
		else $error("select gap too short");
	a_resp_pulse: assert property (resp_valid_o |=> !resp_valid_o)
		else $error("response longer than one cycle");
	a_idle_quiet: assert property (cmd_ready_o |-> flag_space_select_n_o)
		else $error("select active while idle");
	a_data_hold: assert property ($rose(write_n_o) |-> data_oe_o)
		else $error("write data released with the strobe");
	a_addr_steady: assert property (!flag_space_select_n_o |=> flag_space_select_n_o || $stable(sem_addr_o))
		else $error("address moved during an access");
	cover property (resp_valid_o);
	cover property ($fell(write_n_o));
	cover property ($fell(read_enable_n_o));
endmodule
bind dpsem_host dpsem_mon dpsem_mon_inst (.clock_i(clock_i), .arst_n_i(arst_n_i),
	.cmd_ready_o(cmd_ready_o), .resp_valid_o(resp_valid_o), .data_oe_o(data_oe_o),
	.sem_addr_o(sem_addr_o),
	.flag_space_select_n_o(flag_space_select_n_o), .write_n_o(write_n_o),
	.read_enable_n_o(read_enable_n_o), .data_out_o(data_out_o));

// ===== verification/dpsem_dev.sv
// Purpose: behavioural model of the eight shared semaphore flags
// Assumes: left port is the host, right port is the bench
// Notes: clockless; request latches start unknown
`timescale 1ns/1ps
module dpsem_dev (
	input wire [2:0] la_i,
	input wire ls_n_i,
	input wire lw_n_i,
	input wire lo_n_i,
	input wire [15:0] ld_i,
	output wire [15:0] lq_o,
	input wire [2:0] ra_i,
	input wire rs_n_i,
	input wire rw_n_i,
	input wire ro_n_i,
	input wire [15:0] rd_i,
	output wire [15:0] rq_o
);
	reg [7:0] rl, rr; // request latches, no preset
	reg [7:0] gl = 8'h00, gr = 8'h00; // token held per side
	reg [15:0] ql = 16'h0000, qr = 16'h0000;
	integer i;
	// request latches follow bit zero while writing
	always @* if (!ls_n_i && !lw_n_i) rl[la_i] = ld_i[0];
	always @* if (!rs_n_i && !rw_n_i) rr[ra_i] = rd_i[0];
	// flag logic: first low wins, release hands over, left wins a tie
	always @(rl or rr) for (i = 0; i < 8; i = i + 1) begin
		if (gl[i] && rl[i] === 1'h1) {gl[i], gr[i]} = {1'h0, rr[i] === 1'h0};
		if (gr[i] && rr[i] === 1'h1) {gr[i], gl[i]} = {1'h0, rl[i] === 1'h0};
		if (!gl[i] && !gr[i]) {gl[i], gr[i]} = {rl[i] === 1'h0, rl[i] !== 1'h0 && rr[i] === 1'h0};
	end
	// read value latched as select and enable go active, no state change
	always @(negedge ls_n_i or negedge lo_n_i) if (!ls_n_i && !lo_n_i) ql = {16{!gl[la_i]}};
	always @(negedge rs_n_i or negedge ro_n_i) if (!rs_n_i && !ro_n_i) qr = {16{!gr[ra_i]}};
	// released bus shows the inverse of the last value
	assign lq_o = (!ls_n_i && !lo_n_i) ? ql : ~ql;
	assign rq_o = (!rs_n_i && !ro_n_i) ? qr : ~qr;
endmodule

// ===== verification/testbench.sv
// Purpose: self-checking bench for the host port controller
// Assumes: bench acts as the right port processor
// Notes: inputs change at the falling edge
`timescale 1ns/1ps
`include "dpsem_defines.vh"
module testbench;
	reg clock_i = 1'h0, arst_n_i = 1'h0, cmd_valid_i = 1'h0;
	reg [1:0] cmd_op_i = 2'h0;
	reg [2:0] cmd_index_i = 3'h0, ra = 3'h0;
	reg rs_n = 1'h1, rw_n = 1'h1, ro_n = 1'h1;
	reg [15:0] rd = 16'hFFFF;
	wire [15:0] rq, din, dout;
	wire [7:0] owned, pend;
	wire [2:0] addr;
	wire rdy, rv, gr, sel_n, we_n, oe_n, doe;
	integer n_errors = 0, compares = 0, cyc = 0, k, j;
	always #4 clock_i = ~clock_i;
	dpsem_host dpsem_host_inst (.clock_i(clock_i), .arst_n_i(arst_n_i), .cmd_valid_i(cmd_valid_i),
		.cmd_op_i(cmd_op_i), .cmd_index_i(cmd_index_i), .cmd_ready_o(rdy), .resp_valid_o(rv),
		.resp_granted_o(gr), .owned_o(owned), .pending_o(pend), .sem_addr_o(addr),
		.flag_space_select_n_o(sel_n), .write_n_o(we_n), .read_enable_n_o(oe_n),
		.data_oe_o(doe), .data_out_o(dout), .data_in_i(din));
	dpsem_dev dpsem_dev_inst (.la_i(addr), .ls_n_i(sel_n), .lw_n_i(we_n), .lo_n_i(oe_n),
		.ld_i(doe ? dout : 16'hFFFF), .lq_o(din), .ra_i(ra), .rs_n_i(rs_n), .rw_n_i(rw_n),
		.ro_n_i(ro_n), .rd_i(rd), .rq_o(rq));
	// ==========================================
	// shared tasks
	task chk(input [15:0] got, input [15:0] exp);
		compares = compares + 1;
		if (got !== exp) begin
			n_errors = n_errors + 1;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task cmd(input [1:0] op, input [2:0] idx, input g);
		k = 0;
		while (rdy !== 1'h1) @(negedge clock_i);
		{cmd_valid_i, cmd_op_i, cmd_index_i} = {1'h1, op, idx};
		@(negedge clock_i) cmd_valid_i = 1'h0;
		while (rv !== 1'h1 && k < 100) @(negedge clock_i) k = k + 1;
		chk(rv, 1'h1);
		chk(gr, g);
	endtask
	// right port write of bit w, or read when rd_op, checked against e
	task rport(input rd_op, input w, input [2:0] a, input [15:0] e);
		@(negedge clock_i) {ra, rs_n, rw_n, ro_n, rd} = {a, 1'h0, rd_op, !rd_op, {16{w}}};
		repeat (5) @(negedge clock_i);
		if (rd_op) chk(rq, e);
		{rs_n, rw_n, ro_n} = 3'h7;
		@(negedge clock_i);
	endtask
	// ==========================================
	// scenarios
	task t_init;
		rport(0, 1, 0, 0);
		for (j = 0; j < 8; j = j + 1) rport(0, 1, j, 0);
		while (rdy !== 1'h1 && cyc < 300) @(negedge clock_i);
		chk(dpsem_dev_inst.rl, 16'h00FF);
		$display("test init done");
	endtask
	task t_handover;
		cmd(`DPSEM_CMD_CLAIM, 3, 1);
		rport(0, 0, 3, 0);
		rport(1, 0, 3, 16'hFFFF);
		cmd(`DPSEM_CMD_PROBE, 3, 1);
		cmd(`DPSEM_CMD_RELEASE, 3, 0);
		rport(1, 0, 3, 16'h0000);
		cmd(`DPSEM_CMD_CLAIM, 3, 0);
		chk(pend, 16'h0008);
		rport(0, 1, 3, 0);
		cmd(`DPSEM_CMD_PROBE, 3, 1);
		cmd(`DPSEM_CMD_RELEASE, 3, 0);
		$display("test handover done");
	endtask
	task t_all;
		for (j = 0; j < 8; j = j + 1) cmd(`DPSEM_CMD_CLAIM, j, 1);
		chk(owned, 16'h00FF);
		rport(0, 0, 5, 0);
		cmd(`DPSEM_CMD_WITHDRAW, 6, 0);
		for (j = 0; j < 8; j = j + 1) cmd(`DPSEM_CMD_RELEASE, j, 0);
		rport(1, 0, 5, 16'h0000);
		rport(1, 0, 6, 16'hFFFF);
		$display("test all flags done");
	endtask
	// failed claim withdrawn: token must not pass to this side later
	task t_withdraw;
		cmd(`DPSEM_CMD_CLAIM, 5, 0);
		cmd(`DPSEM_CMD_WITHDRAW, 5, 0);
		chk(pend, 16'h0000);
		rport(0, 1, 5, 0);
		rport(1, 0, 5, 16'hFFFF);
		cmd(`DPSEM_CMD_PROBE, 5, 0);
		$display("test withdraw done");
	endtask
	// reset in mid-run: outputs clear, init frees the left latches again
	task t_reset;
		cmd(`DPSEM_CMD_CLAIM, 2, 1);
		arst_n_i = 1'h0;
		@(negedge clock_i);
		chk({rdy, owned}, 16'h0000);
		arst_n_i = 1'h1;
		k = 0;
		while (rdy !== 1'h1 && k < 200) @(negedge clock_i) k = k + 1;
		chk({rdy, owned}, 16'h0100);
		rport(1, 0, 2, 16'hFFFF);
		$display("test reset done");
	endtask
	task results;
		$display("checks %0d mismatches %0d", compares, n_errors);
		if (n_errors == 0 && compares > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask
	// timeout ceiling
	always @(posedge clock_i) begin
		cyc = cyc + 1;
		if (cyc == 5000) begin
			n_errors = n_errors + 1;
			results;
		end
	end
	initial begin
		repeat (20) @(negedge clock_i);
		arst_n_i = 1'h1;
		t_init;
		t_handover;
		t_all;
		t_withdraw;
		t_reset;
		results;
	end
endmodule
